// ### inc/cc_pwr_pkg.sv
// constants for the cc and power status register bank
package cc_pwr_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CC_LINE_STATUS = 8'h1d;
	localparam logic [7:0] OFS_POWER_LINE_STATUS = 8'h1e;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// ----------------------------------------
	// cc_line_status fields
	// ----------------------------------------
	localparam int CC_LOOKING_BIT = 5;
	localparam int CC_PRESENT_RD_BIT = 4;
	localparam int CC_LINE2_LSB = 2;
	localparam int CC_LINE1_LSB = 0;
	localparam logic [7:0] CC_LINE_STATUS_RST = 8'h10;

	// ----------------------------------------
	// power_line_status fields
	// ----------------------------------------
	localparam int PW_DEBUG_BIT = 7;
	localparam int PW_INIT_BIT = 6;
	localparam int PW_HV_SOURCING_BIT = 5;
	localparam int PW_BUS_SOURCING_BIT = 4;
	localparam int PW_MONITOR_BIT = 3;
	localparam int PW_BUS_PRESENT_BIT = 2;
	localparam int PW_CABLE_PRESENT_BIT = 1;
	localparam int PW_BUS_SINKING_BIT = 0;
	localparam logic [7:0] PW_STATUS_RST = 8'h00;

	// ----------------------------------------
	// line state codes
	// ----------------------------------------
	localparam logic [1:0] ST_OPEN = 2'h0;
	localparam logic [1:0] ST_SRC_RA = 2'h1;
	localparam logic [1:0] ST_SRC_RD = 2'h2;
	localparam logic [1:0] ST_SNK_DEFAULT = 2'h1;
	localparam logic [1:0] ST_SNK_1P5 = 2'h2;
	localparam logic [1:0] ST_SNK_3P0 = 2'h3;

	// termination selection per line
	localparam logic [1:0] SEL_RA = 2'h0;
	localparam logic [1:0] SEL_RP = 2'h1;
	localparam logic [1:0] SEL_RD = 2'h2;
	localparam logic [1:0] SEL_OPEN = 2'h3;

	// ----------------------------------------
	// raw detector bundle layout
	// ----------------------------------------
	localparam int RAW_W = 18;
	localparam int RAW_LOOKING = 0;
	localparam int RAW_PRESENT_RD = 1;
	localparam int RAW_DEBUG_B = 2;
	localparam int RAW_INIT = 3;
	localparam int RAW_MONITOR = 4;
	localparam int RAW_ABOVE_4V = 5;
	localparam int RAW_BELOW_3V5 = 6;
	localparam int RAW_CABLE_DET = 7;
	localparam int RAW_LINE1 = 8;
	localparam int RAW_LINE2 = 13;
	localparam int LINE_FLAGS = 5;
	localparam int LF_BELOW_RA = 0;
	localparam int LF_IN_RD = 1;
	localparam int LF_RP_DEF = 2;
	localparam int LF_RP_1P5 = 3;
	localparam int LF_RP_3P0 = 4;
	// presenting rd, debug pin idle high, bus below 3.5 v
	localparam logic [RAW_W-1:0] RAW_RST = 18'h0_0046;

endpackage

// ### inc/detector_if.sv
// bundle of raw detector levels and their synchronised copies
`timescale 1ns/10ps
interface detector_if;
	logic [cc_pwr_pkg::RAW_W-1:0] raw;
	logic [cc_pwr_pkg::RAW_W-1:0] synced;

	modport sync_side (input raw, output synced);
	modport user_side (output raw, input synced);
endinterface

// ### rtl/detector_sync.sv
// two-flop synchroniser for the detector bundle
`timescale 1ns/10ps
module detector_sync
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// detector bundle
	detector_if.sync_side det
);

	logic [cc_pwr_pkg::RAW_W-1:0] meta_ff;
	logic [cc_pwr_pkg::RAW_W-1:0] stable_ff;

	// ----------------------------------------
	// two stages per bit
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			meta_ff <= cc_pwr_pkg::RAW_RST;
			stable_ff <= cc_pwr_pkg::RAW_RST;
		end
		else
		begin
			meta_ff <= det.raw;
			stable_ff <= meta_ff;
		end
	end

	assign det.synced = stable_ff;

endmodule

// ### rtl/cc_and_power_status_regs.sv
// cc and power status registers of a type-c port controller
`timescale 1ns/10ps

// How it works
// - cc_line_status refreshed live, never latched
// - power status refreshed live, never latched
// - bit5 high while searching; fall means found
// - bit4 zero for rp, one for rd
// - rp or bit4 zero: source line encoding
// - rd or bit4 one: sink line encoding
// - ra selection reports open code
// - line2 forced open when searching or enable with flip0
// - line1 forced open when searching or enable with flip1
// - bit7 mirrors debug accessory output
// - bit6 high during internal initialisation
// - bits 5 and 4 always zero
// - bit0 always zero
// - bit3 shows bus presence monitor active
// - bit2 sets above 4v, clears below 3.5v
// - bit1 cable power present, gated by enable
// - enable drives cable power per flip
module cc_and_power_status_regs
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,

	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic reg_wr_en,
	output logic [7:0] reg_rdata_ff,
	output logic reg_ack_ff,

	// control from neighbouring registers, same clock
	input wire logic cable_power_enable,
	input wire logic plug_flip,
	input wire logic [1:0] line1_term_sel,
	input wire logic [1:0] line2_term_sel,

	// analog detector levels, asynchronous
	input wire logic looking_for_attach,
	input wire logic presenting_rd,
	input wire logic debug_accessory_output_b,
	input wire logic init_in_progress,
	input wire logic bus_presence_monitor_on,
	input wire logic bus_above_4v,
	input wire logic bus_below_3v5,
	input wire logic cable_power_detect,
	input wire logic [4:0] line1_flags,
	input wire logic [4:0] line2_flags,

	// derived outputs
	output logic attach_found_ff,
	output logic cable_power_line1_on_ff,
	output logic cable_power_line2_on_ff
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_ff;
	logic rst_sync_ff;

	// every flop below leaves reset on one edge, never mid-cycle,
	// so no register can see half a release

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------
	// detector synchronisation
	// ----------------------------------------
	detector_if det ();

	assign det.raw[cc_pwr_pkg::RAW_LOOKING] = looking_for_attach;
	assign det.raw[cc_pwr_pkg::RAW_PRESENT_RD] = presenting_rd;
	assign det.raw[cc_pwr_pkg::RAW_DEBUG_B] = debug_accessory_output_b;
	assign det.raw[cc_pwr_pkg::RAW_INIT] = init_in_progress;
	assign det.raw[cc_pwr_pkg::RAW_MONITOR] = bus_presence_monitor_on;
	assign det.raw[cc_pwr_pkg::RAW_ABOVE_4V] = bus_above_4v;
	assign det.raw[cc_pwr_pkg::RAW_BELOW_3V5] = bus_below_3v5;
	assign det.raw[cc_pwr_pkg::RAW_CABLE_DET] = cable_power_detect;
	assign det.raw[cc_pwr_pkg::RAW_LINE1 +: cc_pwr_pkg::LINE_FLAGS] =
		line1_flags;
	assign det.raw[cc_pwr_pkg::RAW_LINE2 +: cc_pwr_pkg::LINE_FLAGS] =
		line2_flags;

	// bits of the bundle may settle a cycle apart; a line field built
	// from two flags can show a mixed code for one cycle
	detector_sync u_sync
	(
		.clk(clk),
		.rst_sync_b(rst_sync_ff),
		.det(det.sync_side)
	);

	logic s_looking;
	logic s_present_rd;
	logic s_debug_b;
	logic s_init;
	logic s_monitor;
	logic s_above_4v;
	logic s_below_3v5;
	logic s_cable_det;

	assign s_looking = det.synced[cc_pwr_pkg::RAW_LOOKING];
	assign s_present_rd = det.synced[cc_pwr_pkg::RAW_PRESENT_RD];
	assign s_debug_b = det.synced[cc_pwr_pkg::RAW_DEBUG_B];
	assign s_init = det.synced[cc_pwr_pkg::RAW_INIT];
	assign s_monitor = det.synced[cc_pwr_pkg::RAW_MONITOR];
	assign s_above_4v = det.synced[cc_pwr_pkg::RAW_ABOVE_4V];
	assign s_below_3v5 = det.synced[cc_pwr_pkg::RAW_BELOW_3V5];
	assign s_cable_det = det.synced[cc_pwr_pkg::RAW_CABLE_DET];

	// ----------------------------------------
	// per-line state encoding
	// ----------------------------------------
	logic [1:0] term_sel [2];
	logic [4:0] line_flags [2];
	logic [1:0] line_state [2];
	// value of plug_flip that puts cable power on each line
	localparam logic FORCE_FLIP [2] = '{1'b1, 1'b0};

	assign term_sel[0] = line1_term_sel;
	assign term_sel[1] = line2_term_sel;
	assign line_flags[0] =
		det.synced[cc_pwr_pkg::RAW_LINE1 +: cc_pwr_pkg::LINE_FLAGS];
	assign line_flags[1] =
		det.synced[cc_pwr_pkg::RAW_LINE2 +: cc_pwr_pkg::LINE_FLAGS];

	// same decode for both lines; only the forcing flip differs
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_line
			logic use_source;
			logic use_sink;
			logic forced_open;
			logic [1:0] src_code;
			logic [1:0] snk_code;

			// explicit selection wins; open selection follows bit4
			assign use_source = (term_sel[gi] == cc_pwr_pkg::SEL_RP) ||
				((term_sel[gi] == cc_pwr_pkg::SEL_OPEN) && !s_present_rd);
			assign use_sink = (term_sel[gi] == cc_pwr_pkg::SEL_RD) ||
				((term_sel[gi] == cc_pwr_pkg::SEL_OPEN) && s_present_rd);

			// line carrying cable power cannot be measured
			assign forced_open = s_looking || (cable_power_enable &&
				(plug_flip == FORCE_FLIP[gi]));

			always_comb
			begin
				if (line_flags[gi][cc_pwr_pkg::LF_IN_RD])
					src_code = cc_pwr_pkg::ST_SRC_RD;
				else if (line_flags[gi][cc_pwr_pkg::LF_BELOW_RA])
					src_code = cc_pwr_pkg::ST_SRC_RA;
				else
					src_code = cc_pwr_pkg::ST_OPEN;
			end

			always_comb
			begin
				if (line_flags[gi][cc_pwr_pkg::LF_RP_3P0])
					snk_code = cc_pwr_pkg::ST_SNK_3P0;
				else if (line_flags[gi][cc_pwr_pkg::LF_RP_1P5])
					snk_code = cc_pwr_pkg::ST_SNK_1P5;
				else if (line_flags[gi][cc_pwr_pkg::LF_RP_DEF])
					snk_code = cc_pwr_pkg::ST_SNK_DEFAULT;
				else
					snk_code = cc_pwr_pkg::ST_OPEN;
			end

			always_comb
			begin
				if (forced_open)
					line_state[gi] = cc_pwr_pkg::ST_OPEN;
				else if (term_sel[gi] == cc_pwr_pkg::SEL_RA)
					line_state[gi] = cc_pwr_pkg::ST_OPEN;
				else if (use_source)
					line_state[gi] = src_code;
				else if (use_sink)
					line_state[gi] = snk_code;
				else
					line_state[gi] = cc_pwr_pkg::ST_OPEN;
			end
		end
	endgenerate

	// ----------------------------------------
	// cc_line_status register
	// ----------------------------------------
	logic [7:0] cc_line_status_ff;
	logic [7:0] nxt_cc_line_status;

	always_comb
	begin
		nxt_cc_line_status = 8'h00;
		nxt_cc_line_status[cc_pwr_pkg::CC_LOOKING_BIT] = s_looking;
		nxt_cc_line_status[cc_pwr_pkg::CC_PRESENT_RD_BIT] = s_present_rd;
		nxt_cc_line_status[cc_pwr_pkg::CC_LINE2_LSB +: 2] = line_state[1];
		nxt_cc_line_status[cc_pwr_pkg::CC_LINE1_LSB +: 2] = line_state[0];
	end

	// reserved bits stay zero
	// refreshed every cycle, nothing held
	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			cc_line_status_ff <= cc_pwr_pkg::CC_LINE_STATUS_RST;
		else
			cc_line_status_ff <= nxt_cc_line_status;
	end

	// ----------------------------------------
	// attach found event
	// ----------------------------------------
	logic looking_prev_ff;

	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			looking_prev_ff <= 1'b0;
		else
			looking_prev_ff <= cc_line_status_ff[cc_pwr_pkg::CC_LOOKING_BIT];
	end

	// one-cycle pulse on the falling edge of the looking bit
	// uses the registered bit so the pulse lines up with reads
	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			attach_found_ff <= 1'b0;
		else
			attach_found_ff <= looking_prev_ff &&
				!cc_line_status_ff[cc_pwr_pkg::CC_LOOKING_BIT];
	end

	// ----------------------------------------
	// bus presence hysteresis
	// ----------------------------------------
	logic bus_present_ff;

	// between thresholds the last decision holds
	// low comparator wins, so a sagging bus never reads present
	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			bus_present_ff <= 1'b0;
		else if (s_below_3v5)
			bus_present_ff <= 1'b0;
		else if (s_above_4v)
			bus_present_ff <= 1'b1;
	end

	// ----------------------------------------
	// power status register
	// ----------------------------------------
	logic [7:0] pw_status_ff;
	logic [7:0] nxt_pw_status;

	always_comb
	begin
		nxt_pw_status = 8'h00;
		nxt_pw_status[cc_pwr_pkg::PW_DEBUG_BIT] = !s_debug_b;
		nxt_pw_status[cc_pwr_pkg::PW_INIT_BIT] = s_init;
		nxt_pw_status[cc_pwr_pkg::PW_HV_SOURCING_BIT] = 1'b0;
		nxt_pw_status[cc_pwr_pkg::PW_BUS_SOURCING_BIT] = 1'b0;
		nxt_pw_status[cc_pwr_pkg::PW_MONITOR_BIT] = s_monitor;
		nxt_pw_status[cc_pwr_pkg::PW_BUS_PRESENT_BIT] = bus_present_ff;
		nxt_pw_status[cc_pwr_pkg::PW_CABLE_PRESENT_BIT] =
			s_cable_det && cable_power_enable;
		nxt_pw_status[cc_pwr_pkg::PW_BUS_SINKING_BIT] = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			pw_status_ff <= cc_pwr_pkg::PW_STATUS_RST;
		else
			pw_status_ff <= nxt_pw_status;
	end

	// ----------------------------------------
	// cable power switches
	// ----------------------------------------
	// the flip value selects the line not used for signalling
	// registered so the switch drive never glitches on a flip change
	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			cable_power_line1_on_ff <= 1'b0;
			cable_power_line2_on_ff <= 1'b0;
		end
		else
		begin
			cable_power_line1_on_ff <= cable_power_enable && plug_flip;
			cable_power_line2_on_ff <= cable_power_enable && !plug_flip;
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	logic [7:0] nxt_rdata;

	always_comb
	begin
		unique case (reg_addr)
			cc_pwr_pkg::OFS_CC_LINE_STATUS:
				nxt_rdata = cc_line_status_ff;
			cc_pwr_pkg::OFS_POWER_LINE_STATUS:
				nxt_rdata = pw_status_ff;
			default:
				nxt_rdata = cc_pwr_pkg::UNMAPPED_DATA;
		endcase
	end

	// one cycle answer, no wait states; reads never disturb status
	// read data only changes on a read; writes only acknowledge
	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			reg_rdata_ff <= 8'h00;
		else if (reg_rd_en)
			reg_rdata_ff <= nxt_rdata;
	end

	always_ff @(posedge clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			reg_ack_ff <= 1'b0;
		else
			reg_ack_ff <= reg_rd_en || reg_wr_en;
	end

endmodule

// ### verif/port_manager_model.sv
// port manager model issuing single-byte register requests
`timescale 1ns/10ps
module port_manager_model
(
	// clock
	input wire logic clk,
	// register access
	output logic [7:0] reg_addr,
	output logic reg_rd_en,
	output logic reg_wr_en,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic reg_ack_ff
);
	initial
	begin
		reg_addr = 8'h00;
		reg_rd_en = 1'b0;
		reg_wr_en = 1'b0;
	end

	// one-cycle request pulse, then a bounded wait for the ack
	task automatic access(input logic [7:0] addr, input logic wr,
		output logic [7:0] data, output logic acked);
		int n;
		reg_addr <= addr;
		reg_rd_en <= !wr;
		reg_wr_en <= wr;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		reg_wr_en <= 1'b0;
		acked = 1'b0;
		data = 8'h00;
		for (n = 0; n < 4 && !acked; n++)
		begin
			@(posedge clk);
			acked = (reg_ack_ff === 1'b1);
			data = reg_rdata_ff;
		end
	endtask
endmodule

// ### verif/cc_pwr_properties.sv
// concurrent checks on the status register bank ports
`timescale 1ns/10ps
module cc_pwr_properties
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register access
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic reg_ack_ff,
	// levels and derived outputs
	input wire logic cable_power_enable,
	input wire logic plug_flip,
	input wire logic looking_for_attach,
	input wire logic bus_above_4v,
	input wire logic bus_below_3v5,
	input wire logic attach_found_ff,
	input wire logic cable_power_line1_on_ff,
	input wire logic cable_power_line2_on_ff
);
	logic [3:0] up_cnt_ff;

	// $past reaches back into reset, so hold off a while
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			up_cnt_ff <= 4'h0;
		else if (up_cnt_ff != 4'hf)
			up_cnt_ff <= up_cnt_ff + 4'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b || up_cnt_ff != 4'hf);

	sequence rd_cc;
		reg_rd_en && reg_addr == cc_pwr_pkg::OFS_CC_LINE_STATUS;
	endsequence
	sequence rd_pw;
		reg_rd_en && reg_addr == cc_pwr_pkg::OFS_POWER_LINE_STATUS;
	endsequence

	ack_after_req_a:
		assert property ((reg_rd_en || reg_wr_en) |=> reg_ack_ff)
		else $error("ack missing");
	ack_pulse_a:
		assert property (!(reg_rd_en || reg_wr_en) |=> !reg_ack_ff)
		else $error("ack without request");
	write_keeps_data_a:
		assert property ((reg_wr_en && !reg_rd_en) |=> $stable(reg_rdata_ff))
		else $error("write changed read data");
	unused_bits_zero_a:
		assert property (rd_pw |=> reg_rdata_ff[5:4] == 2'h0 && !reg_rdata_ff[0])
		else $error("unused power bit set");
	cc_reserved_zero_a:
		assert property (rd_cc |=> reg_rdata_ff[7:6] == 2'h0)
		else $error("reserved cc bit set");
	looking_bit_a:
		assert property ($stable(looking_for_attach)[*6] ##0 rd_cc
			|=> reg_rdata_ff[5] == $past(looking_for_attach))
		else $error("search bit wrong");
	attach_pulse_a:
		assert property ($fell(looking_for_attach) |-> ##[3:6] attach_found_ff)
		else $error("attach pulse missing");
	cable_route_a:
		assert property (cable_power_enable |=> cable_power_line1_on_ff ==
			$past(plug_flip) && cable_power_line2_on_ff == !$past(plug_flip))
		else $error("cable power on wrong line");
	bus_clear_a:
		assert property (bus_below_3v5[*6] ##0 rd_pw |=> !reg_rdata_ff[2])
		else $error("bus present below low level");
	bus_set_a:
		assert property ((bus_above_4v && !bus_below_3v5)[*6] ##0 rd_pw
			|=> reg_rdata_ff[2])
		else $error("bus absent above high level");
	cable_gate_a:
		assert property ((!cable_power_enable)[*3] ##0 rd_pw |=> !reg_rdata_ff[1])
		else $error("cable power present while disabled");
endmodule

bind cc_and_power_status_regs cc_pwr_properties u_cc_pwr_properties
(
	.clk, .rst_b, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_rdata_ff,
	.reg_ack_ff, .cable_power_enable, .plug_flip, .looking_for_attach,
	.bus_above_4v, .bus_below_3v5, .attach_found_ff,
	.cable_power_line1_on_ff, .cable_power_line2_on_ff
);

// ### verif/testbench.sv
// self-checking bench for the cc and power status registers
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr, reg_rdata_ff, got;
	logic reg_rd_en, reg_wr_en, reg_ack_ff, acked;
	logic cable_power_enable, plug_flip, looking_for_attach, presenting_rd;
	logic debug_accessory_output_b, init_in_progress, bus_presence_monitor_on;
	logic bus_above_4v, bus_below_3v5, cable_power_detect;
	logic [1:0] line1_term_sel, line2_term_sel, e1, e2;
	logic [4:0] line1_flags, line2_flags;
	logic attach_found_ff, cable_power_line1_on_ff, cable_power_line2_on_ff;
	logic [7:0] n_attach = 8'h00;
	int n_mismatch = 0;
	int checked = 0;
	logic [6:0] pw_in [8] = '{7'h08, 7'h68, 7'h58, 7'h44, 7'h40, 7'h43,
		7'h4e, 7'h49};
	logic [7:0] pw_out [8] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h04, 8'h06,
		8'h00, 8'h00};
	logic [4:0] fl [5] = '{5'h03, 5'h01, 5'h1c, 5'h0c, 5'h04};
	logic [7:0] fc_out [3] = '{8'h30, 8'h1c, 8'h13};

	always #2 clk = ~clk;

	always @(posedge clk)
		if (attach_found_ff === 1'b1)
			n_attach <= n_attach + 8'h01;

	cc_and_power_status_regs u_cc_and_power_status_regs
	(
		.clk, .rst_b, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_rdata_ff,
		.reg_ack_ff, .cable_power_enable, .plug_flip, .line1_term_sel,
		.line2_term_sel, .looking_for_attach, .presenting_rd,
		.debug_accessory_output_b, .init_in_progress,
		.bus_presence_monitor_on, .bus_above_4v, .bus_below_3v5,
		.cable_power_detect, .line1_flags, .line2_flags, .attach_found_ff,
		.cable_power_line1_on_ff, .cable_power_line2_on_ff
	);

	port_manager_model u_port_manager_model
	(
		.clk, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_rdata_ff, .reg_ack_ff
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// detectors need a few edges through the synchroniser first
	task automatic read_reg(input logic [7:0] addr, input logic [7:0] exp);
		repeat (8) @(posedge clk);
		u_port_manager_model.access(addr, 1'b0, got, acked);
		check({7'h00, acked}, 8'h01);
		check(got, exp);
	endtask

	function automatic logic [1:0] exp_line(input logic [1:0] sel,
		input logic p, input logic [4:0] f);
		if (sel == cc_pwr_pkg::SEL_RA)
			return 2'h0;
		if (sel == cc_pwr_pkg::SEL_RP || (sel == cc_pwr_pkg::SEL_OPEN && !p))
			return f[1] ? 2'h2 : (f[0] ? 2'h1 : 2'h0);
		return f[4] ? 2'h3 : (f[3] ? 2'h2 : (f[2] ? 2'h1 : 2'h0));
	endfunction

	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		{cable_power_enable, plug_flip, looking_for_attach} = 3'h0;
		{init_in_progress, bus_presence_monitor_on} = 2'h0;
		{bus_above_4v, cable_power_detect} = 2'h0;
		{presenting_rd, debug_accessory_output_b, bus_below_3v5} = 3'h7;
		{line1_term_sel, line2_term_sel} = 4'hf;
		{line1_flags, line2_flags} = 10'h000;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		read_reg(8'h1e, 8'h00);
		read_reg(8'h40, cc_pwr_pkg::UNMAPPED_DATA);
		read_reg(8'h1d, 8'h10);
		// a write must leave the last read data alone
		u_port_manager_model.access(8'h1e, 1'b1, got, acked);
		check({7'h00, acked}, 8'h01);
		check(got, 8'h10);
		// power detectors one by one, then the comparator hysteresis
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			{debug_accessory_output_b, init_in_progress, bus_presence_monitor_on,
				bus_below_3v5, bus_above_4v, cable_power_enable,
				cable_power_detect} <= pw_in[i];
			read_reg(8'h1e, pw_out[i]);
		end
		// every selection against each flag pattern and both roles
		for (int i = 0; i < 40; i++)
		begin
			@(posedge clk);
			line1_term_sel <= i[1:0];
			line2_term_sel <= ~i[1:0];
			presenting_rd <= i[2];
			line1_flags <= fl[i / 8];
			line2_flags <= fl[4 - i / 8];
			e1 = exp_line(i[1:0], i[2], fl[i / 8]);
			e2 = exp_line(~i[1:0], i[2], fl[4 - i / 8]);
			read_reg(8'h1d, {3'h0, i[2], e2, e1});
		end
		// forced open codes while searching or powering a cable line
		@(posedge clk);
		{line1_term_sel, line2_term_sel} <= {2{cc_pwr_pkg::SEL_RD}};
		{line1_flags, line2_flags} <= 10'h210;
		presenting_rd <= 1'b1;
		read_reg(8'h1d, 8'h1f);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			looking_for_attach <= (i == 0);
			cable_power_enable <= (i != 0);
			plug_flip <= (i == 1);
			read_reg(8'h1d, fc_out[i]);
			got = {6'h00, cable_power_line2_on_ff, cable_power_line1_on_ff};
			check(got, {6'h00, i == 2, i == 1});
		end
		check(n_attach, 8'h01);
		give_verdict();
	end
endmodule
